/* File: emc_pkg.sv */
// Constants for the two-wire memory host: bus timing, select byte layout, command codes.
// Assumes a 200 MHz ref_clk; every count of cycles here is derived from that rate.

package emc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  // Quarter of a serial clock bit; high and low phases are two quarters each, except a stop bit, which holds the clock high for three
  localparam int SCL_QUARTER_NS = 650;
  localparam int QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_TIME_US = 10000;
  localparam int PROG_TIME_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Select byte and transfer limits
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_FIXED_BITS = 3'h0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [6:0] PAGE_BYTES = 7'h40;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic SCL_RESET = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BIT_START = 2'h0,
    BIT_STOP = 2'h1,
    BIT_WRITE = 2'h2,
    BIT_READ = 2'h3
  } emc_bit_op_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_RAND_READ = 2'h1,
    OP_CUR_READ = 2'h2
  } emc_cmd_t;

  typedef enum logic [2:0] {
    PH_SEL = 3'h0,
    PH_ADDR_HI = 3'h1,
    PH_ADDR_LO = 3'h2,
    PH_DATA = 3'h3,
    PH_RSEL = 3'h4,
    PH_POLL = 3'h5
  } emc_phase_t;

  // Gray codes along idle, start, send, ack, receive, ack, stop, finish
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_TXBIT = 3'h3,
    ST_TXACK = 3'h2,
    ST_RXBIT = 3'h6,
    ST_RXACK = 3'h7,
    ST_STOP = 3'h5,
    ST_FINISH = 3'h4
  } emc_state_t;

endpackage

/* File: emc_bit_engine.sv */
// Serial bit engine: one start, stop, data-out or data-in bit per request.
// Assumes go is a one-cycle pulse from ref_clk logic, given only while idle.
`timescale 1ns/1ps

module emc_bit_engine
  import emc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [1:0] op,
  input wire logic din,
  input wire logic sda_in,
  output logic done,
  output logic dout,
  output logic scl_out,
  output logic sda_oe
);

  logic sda_meta_reg;
  logic sda_sync_reg;
  logic active_reg;
  logic [1:0] phase_reg;
  logic [7:0] qcnt_reg;
  logic [1:0] op_reg;
  logic din_reg;

  // ---------------------------------------------------------------
  // Line levels per quarter: {clock, data pulled low}
  // ---------------------------------------------------------------
  function automatic logic [1:0] drive(input logic [1:0] o, input logic [1:0] ph, input logic d);
    logic clk_hi;
    clk_hi = (ph == 2'h1) || (ph == 2'h2);
    case (o)
      BIT_START: drive = {ph[0] ^ ph[1], ph[1]};         // data falls in the high phase
      BIT_STOP: drive = {ph != 2'h0, ph == 2'h0 || ph == 2'h1};
      BIT_WRITE: drive = {clk_hi, ~d};                    // data set while clock low
      default: drive = {clk_hi, 1'b0};                    // line released to read
    endcase
  endfunction

  // Two-flop synchroniser on the data pin
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Quarter sequencer
  // ---------------------------------------------------------------
  // Clock is made here from ref_clk, so the engine alone paces the bus
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_reg <= 1'b0;
      phase_reg <= 2'h0;
      qcnt_reg <= 8'h00;
      op_reg <= 2'h0;
      din_reg <= 1'b0;
      done <= 1'b0;
      dout <= 1'b1;
      scl_out <= SCL_RESET;
      sda_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!active_reg) begin
        if (go) begin
          active_reg <= 1'b1;
          phase_reg <= 2'h0;
          qcnt_reg <= 8'h00;
          op_reg <= op;
          din_reg <= din;
          {scl_out, sda_oe} <= drive(op, 2'h0, din);
        end
      end else if (qcnt_reg == 8'(QUARTER_CYC - 1)) begin
        qcnt_reg <= 8'h00;
        // Sample late in the high phase, well after the rising edge
        if (phase_reg == 2'h2) begin
          dout <= sda_sync_reg;
        end
        if (phase_reg == 2'h3) begin
          active_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          phase_reg <= phase_reg + 2'h1;
          {scl_out, sda_oe} <= drive(op_reg, phase_reg + 2'h1, din_reg);
        end
      end else begin
        qcnt_reg <= qcnt_reg + 8'h01;
      end
    end
  end

endmodule

/* File: emc_host.sv */
// Host controller for a two-wire serial memory: writes, random and current reads, ack polling.
// Assumes single master on the bus, one command at a time, and the memory on open-drain data.
`timescale 1ns/1ps

module emc_host
  import emc_pkg::*;
#(
  // Arbitrary type code; set it to the type code of the attached memory
  parameter logic [3:0] DEV_TYPE_CODE = 4'h5,
  parameter int PROG_TIMEOUT_CYC = PROG_TIME_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [6:0] cmd_len,
  input wire logic [7:0] wr_data,
  input wire logic protect_req,
  input wire logic dev_power_ok,
  input wire logic sda_in,
  output logic busy,
  output logic done,
  output logic err,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic scl_out,
  output logic sda_out,
  output logic sda_oe,
  output logic write_protect_in
);

  emc_state_t state_reg;
  emc_phase_t phase_reg;
  emc_cmd_t op_reg;
  logic [15:0] addr_reg;
  logic [6:0] left_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_idx_reg;
  logic poll_pend_reg;
  logic fail_reg;
  logic [21:0] poll_cnt_reg;
  logic pwr_meta_reg;
  logic pwr_ok_reg;
  logic go_reg;
  logic [1:0] bop_reg;
  logic bdin_reg;
  logic bit_done;
  logic bit_dout;
  logic [6:0] len_eff;
  logic poll_expired;

  // ---------------------------------------------------------------
  // Pin engine
  // ---------------------------------------------------------------
  emc_bit_engine u_bits (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .go(go_reg),
    .op(bop_reg),
    .din(bdin_reg),
    .sda_in(sda_in),
    .done(bit_done),
    .dout(bit_dout),
    .scl_out(scl_out),
    .sda_oe(sda_oe)
  );

  // Zero and oversize lengths are clamped to one page
  assign len_eff = (cmd_len == 7'h00 || cmd_len > PAGE_BYTES) ? PAGE_BYTES : cmd_len;
  assign poll_expired = poll_cnt_reg >= 22'(PROG_TIMEOUT_CYC);

  // ---------------------------------------------------------------
  // Power gate and protect pin
  // ---------------------------------------------------------------
  // Power status comes from outside this clock, so it is synchronised
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pwr_meta_reg <= 1'b0;
      pwr_ok_reg <= 1'b0;
    end else begin
      pwr_meta_reg <= dev_power_ok;
      pwr_ok_reg <= pwr_meta_reg;
    end
  end

  // Protect level follows the user request; reset leaves writes allowed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_protect_in <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      write_protect_in <= protect_req;
      sda_out <= 1'b0;                                    // only ever pulls low
    end
  end

  // ---------------------------------------------------------------
  // Program-cycle poll timer
  // ---------------------------------------------------------------
  // Bounds ack polling so a dead memory cannot hang the host
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      poll_cnt_reg <= 22'h000000;
    end else if (!poll_pend_reg) begin
      poll_cnt_reg <= 22'h000000;
    end else if (!poll_expired) begin
      poll_cnt_reg <= poll_cnt_reg + 22'h000001;
    end
  end

  // ---------------------------------------------------------------
  // Transaction sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_SEL;
      op_reg <= OP_WRITE;
      addr_reg <= 16'h0000;
      left_reg <= 7'h00;
      shift_reg <= BYTE_RESET;
      bit_idx_reg <= 3'h0;
      poll_pend_reg <= 1'b0;
      fail_reg <= 1'b0;
      go_reg <= 1'b0;
      bop_reg <= BIT_STOP;
      bdin_reg <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      wr_take <= 1'b0;
      rd_data <= BYTE_RESET;
      rd_valid <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      done <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Commands wait while the memory is held off by its power gate
          if (cmd_valid && pwr_ok_reg) begin
            op_reg <= emc_cmd_t'(cmd_op);
            addr_reg <= cmd_addr;                           // upper bits passed as given
            left_reg <= len_eff;
            phase_reg <= PH_SEL;
            fail_reg <= 1'b0;
            busy <= 1'b1;
            err <= 1'b0;
            bop_reg <= BIT_START;
            go_reg <= 1'b1;
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (bit_done) begin
            // Select byte: type code, fixed bits, direction
            if (phase_reg == PH_RSEL || (phase_reg == PH_SEL && op_reg == OP_CUR_READ)) begin
              shift_reg <= {DEV_TYPE_CODE, SEL_FIXED_BITS, RW_READ};
              bdin_reg <= DEV_TYPE_CODE[3];
            end else begin
              shift_reg <= {DEV_TYPE_CODE, SEL_FIXED_BITS, RW_WRITE};
              bdin_reg <= DEV_TYPE_CODE[3];
            end
            bit_idx_reg <= LAST_BIT_IDX;
            bop_reg <= BIT_WRITE;
            go_reg <= 1'b1;
            state_reg <= ST_TXBIT;
          end
        end
        ST_TXBIT: begin
          if (bit_done) begin
            if (bit_idx_reg == 3'h0) begin
              // Release the line and read the acknowledge slot
              bop_reg <= BIT_READ;
              state_reg <= ST_TXACK;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              bdin_reg <= shift_reg[6];
              bit_idx_reg <= bit_idx_reg - 3'h1;
              bop_reg <= BIT_WRITE;
            end
            go_reg <= 1'b1;
          end
        end
        ST_TXACK: begin
          if (bit_done) begin
            go_reg <= 1'b1;
            bit_idx_reg <= LAST_BIT_IDX;
            bop_reg <= BIT_WRITE;
            state_reg <= ST_TXBIT;
            if (bit_dout) begin
              // No acknowledge: retry polls, fail anything else
              bop_reg <= BIT_STOP;
              state_reg <= ST_STOP;
              if (phase_reg != PH_POLL) begin
                fail_reg <= 1'b1;
                poll_pend_reg <= 1'b0;
              end
            end else begin
              case (phase_reg)
                PH_SEL: begin
                  if (op_reg == OP_CUR_READ) begin
                    bop_reg <= BIT_READ;
                    state_reg <= ST_RXBIT;
                  end else begin
                    phase_reg <= PH_ADDR_HI;                // high byte first
                    shift_reg <= addr_reg[15:8];
                    bdin_reg <= addr_reg[15];
                  end
                end
                PH_ADDR_HI: begin
                  phase_reg <= PH_ADDR_LO;
                  shift_reg <= addr_reg[7:0];
                  bdin_reg <= addr_reg[7];
                end
                PH_ADDR_LO: begin
                  if (op_reg == OP_WRITE) begin
                    phase_reg <= PH_DATA;
                    shift_reg <= wr_data;
                    bdin_reg <= wr_data[7];
                    wr_take <= 1'b1;
                  end else begin
                    // Dummy write done; repeated start turns the bus round
                    phase_reg <= PH_RSEL;
                    bop_reg <= BIT_START;
                    state_reg <= ST_START;
                  end
                end
                PH_DATA: begin
                  if (left_reg == 7'h01) begin
                    // Stop right after the ack slot starts programming
                    left_reg <= 7'h00;
                    poll_pend_reg <= 1'b1;
                    bop_reg <= BIT_STOP;
                    state_reg <= ST_STOP;
                  end else begin
                    // Caller keeps bytes inside one row; the memory wraps otherwise
                    left_reg <= left_reg - 7'h01;
                    shift_reg <= wr_data;
                    bdin_reg <= wr_data[7];
                    wr_take <= 1'b1;
                  end
                end
                PH_RSEL: begin
                  bop_reg <= BIT_READ;
                  state_reg <= ST_RXBIT;
                end
                default: begin
                  // Poll answered: programming has finished
                  poll_pend_reg <= 1'b0;
                  bop_reg <= BIT_STOP;
                  state_reg <= ST_STOP;
                end
              endcase
            end
          end
        end
        ST_RXBIT: begin
          if (bit_done) begin
            shift_reg <= {shift_reg[6:0], bit_dout};
            if (bit_idx_reg == 3'h0) begin
              rd_data <= {shift_reg[6:0], bit_dout};
              rd_valid <= 1'b1;
              left_reg <= left_reg - 7'h01;
              // Acknowledge all but the last byte
              bop_reg <= BIT_WRITE;
              bdin_reg <= (left_reg == 7'h01);
              state_reg <= ST_RXACK;
            end else begin
              bit_idx_reg <= bit_idx_reg - 3'h1;
              bop_reg <= BIT_READ;
            end
            go_reg <= 1'b1;
          end
        end
        ST_RXACK: begin
          if (bit_done) begin
            go_reg <= 1'b1;
            if (left_reg == 7'h00) begin
              bop_reg <= BIT_STOP;
              state_reg <= ST_STOP;
            end else begin
              bit_idx_reg <= LAST_BIT_IDX;
              bop_reg <= BIT_READ;
              state_reg <= ST_RXBIT;
            end
          end
        end
        ST_STOP: begin
          if (bit_done) begin
            if (poll_pend_reg && !poll_expired) begin
              // Memory deaf while programming; keep asking with a write select
              phase_reg <= PH_POLL;
              bop_reg <= BIT_START;
              go_reg <= 1'b1;
              state_reg <= ST_START;
            end else begin
              if (poll_pend_reg) begin
                fail_reg <= 1'b1;
              end
              poll_pend_reg <= 1'b0;
              state_reg <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          busy <= 1'b0;
          done <= 1'b1;
          err <= fail_reg;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: emc_host_properties.sv */
// Checker for the two-wire memory host, watching only its top-level ports.
// Assumes one ref_clk domain and an asynchronous, active-low resetn.
`timescale 1ns/1ps

module emc_host_properties #(
  parameter int PROG_TIMEOUT_CYC = 20000
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic busy,
  input wire logic done,
  input wire logic err,
  input wire logic wr_take,
  input wire logic rd_valid,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic protect_req,
  input wire logic write_protect_in,
  input wire logic dev_power_ok
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_wp_follow;
    $past(resetn) |-> write_protect_in == $past(protect_req);
  endproperty
  a_wp_follow: assert property (p_wp_follow) else $error("protect pin lags request wrongly");

  property p_drain;
    sda_out == 1'h0;
  endproperty
  a_drain: assert property (p_drain) else $error("data line driven high");

  // Data may move under a high clock only late, as start or stop
  property p_hold;
    $changed(sda_oe) && scl_out |-> $past(scl_out, 64);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved near clock rise");

  property p_start;
    $rose(busy) |-> ##[1:700] (scl_out && $rose(sda_oe));
  endproperty
  a_start: assert property (p_start) else $error("no start after accept");

  // A new command may be taken right after done, so busy is only checked with done
  property p_done;
    done |-> !busy ##1 !done;
  endproperty
  a_done: assert property (p_done) else $error("done not a single closing pulse");

  property p_idle;
    !busy && !done |-> scl_out && !sda_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not released while idle");

  property p_rd;
    rd_valid |-> busy ##1 !rd_valid;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe malformed");

  property p_take;
    wr_take |-> busy ##1 !wr_take;
  endproperty
  a_take: assert property (p_take) else $error("write take malformed");

  property p_power;
    !dev_power_ok && !$past(dev_power_ok) && !$past(dev_power_ok, 2) && !busy |=> !busy;
  endproperty
  a_power: assert property (p_power) else $error("command taken with power low");

  c_err: cover property (done && err);
  c_rd: cover property (rd_valid);
  c_take: cover property (wr_take);
endmodule

bind emc_host emc_host_properties #(.PROG_TIMEOUT_CYC(PROG_TIMEOUT_CYC)) u_props (.ref_clk(ref_clk),
  .resetn(resetn), .busy(busy), .done(done), .err(err), .wr_take(wr_take), .rd_valid(rd_valid),
  .scl_out(scl_out), .sda_out(sda_out), .sda_oe(sda_oe), .protect_req(protect_req),
  .write_protect_in(write_protect_in), .dev_power_ok(dev_power_ok));

/* File: emc_mem_model.sv */
// Behavioural two-wire memory on the far side of the host.
// Assumes scl is push-pull from the host and sda has a pull-up outside.
`timescale 1ns/1ps

module emc_mem_model #(
  parameter int PROG_NS = 30000
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic wp_pin,
  input wire logic power_ok,
  input wire logic [3:0] type_code,
  output logic pull_low
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] rd_byte;
  logic [14:0] ptr; // Top address bit dropped
  logic active, prog, ack_ok, rw;
  int cnt, phase, nw;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
    active = 0;
    prog = 0;
    pull_low = 0;
  end

  // Next output byte; counter moves after each load
  task nxt;
    rd_byte = mem[ptr[7:0]];
    ptr = ptr + 1;
  endtask

  // Start or restart under a high clock
  always @(negedge sda) if (scl && power_ok) begin
    active = 1;
    cnt = 0;
    phase = 0;
    nw = 0;
  end

  // Stop: program only right after a data ack slot
  always @(posedge sda) if (scl && active) begin
    if (phase == 3 && nw > 0 && cnt == 1) prog = 1;
    active = 0;
  end

  always @(posedge prog) begin
    #(PROG_NS);
    prog = 0;
  end

  // Sample on rising clock, MSB first
  always @(posedge scl) if (active) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt++;
      if (cnt == 8 && phase != 4) begin
        case (phase)
          0: begin
            ack_ok = (sh[7:1] == {type_code, 3'h0}) && !prog;
            rw = sh[0];
          end
          1: begin
            ptr[14:8] = sh[6:0];
            ack_ok = 1;
          end
          2: begin
            ptr[7:0] = sh;
            ack_ok = 1;
          end
          default: begin
            ack_ok = (wp_pin !== 1'h1);
            if (ack_ok) begin
              mem[ptr[7:0]] = sh;
              ptr[5:0] = ptr[5:0] + 1;
              nw++;
            end
          end
        endcase
      end
    end else begin
      cnt = 0;
      if (phase == 4) begin
        if (sda) active = 0;
        else nxt();
      end else if (!ack_ok) active = 0;
      else if (phase == 0 && rw) begin
        phase = 4;
        nxt();
      end else if (phase < 3) phase++;
    end
  end

  // Drive only after a falling clock; release is the only high
  always @(negedge scl) begin
    if (!active) pull_low = 0;
    else if (cnt == 8) pull_low = (phase != 4) && ack_ok;
    else pull_low = (phase == 4) && !rd_byte[7 - cnt];
  end
endmodule

/* File: emc_host_test.sv */
// Self-checking bench for the two-wire memory host against a memory model.
// Assumes the checker binds itself to the host; inputs move on falling ref_clk.
`timescale 1ns/1ps

module emc_host_test;
  import emc_pkg::*;
  logic ref_clk, resetn, cmd_valid, protect_req, dev_power_ok;
  logic [1:0] cmd_op;
  logic [15:0] cmd_addr;
  logic [6:0] cmd_len;
  logic [7:0] wr_data, rd_data;
  logic busy, done, err, wr_take, rd_valid, scl_out, sda_out, sda_oe, write_protect_in, mem_pull, sda;
  logic [3:0] code;
  logic [7:0] wq [0:2];
  logic [7:0] rq [$];
  int failures, num_checks, wi, cyc;

  // Wired-AND data line with pull-up
  assign sda = (sda_oe ? sda_out : 1'h1) && !mem_pull;

  // Type code 4'h9 is arbitrary; model and host share it
  emc_host #(.DEV_TYPE_CODE(4'h9), .PROG_TIMEOUT_CYC(20000)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data),
    .protect_req(protect_req), .dev_power_ok(dev_power_ok), .sda_in(sda), .busy(busy), .done(done),
    .err(err), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .scl_out(scl_out),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_in(write_protect_in));

  emc_mem_model i_mem (.scl(scl_out), .sda(sda), .wp_pin(write_protect_in), .power_ok(dev_power_ok),
    .type_code(code), .pull_low(mem_pull));

  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Hang guard, a little above the expected length of the whole bench
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 105000) begin
      failures++;
      results();
    end
  end

  // Collect read bytes, feed the next write byte after each take
  always @(negedge ref_clk) begin
    if (rd_valid === 1'h1) rq.push_back(rd_data);
    if (wr_take === 1'h1) begin
      wi++;
      wr_data <= wq[wi % 3];
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One command: hold request until taken, then wait for done
  task automatic run(input logic [1:0] op, input logic [15:0] a, input logic [6:0] n, input logic e);
    int t;
    t = 0;
    rq.delete();
    wi = 0;
    wr_data = wq[0];
    cmd_op = op;
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1;
    while (busy !== 1'h1 && t < 20) begin
      @(negedge ref_clk);
      t++;
    end
    cmd_valid = 0;
    while (done !== 1'h1 && t < 60000) begin
      @(negedge ref_clk);
      t++;
    end
    chk({done, err}, {1'h1, e});
    @(negedge ref_clk);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    resetn = 0;
    cmd_valid = 0;
    cmd_op = 0;
    cmd_addr = 0;
    cmd_len = 0;
    wr_data = 0;
    protect_req = 0;
    dev_power_ok = 1;
    code = 4'h9;
    wq[0] = 8'hA5;
    wq[1] = 8'h3C;
    wq[2] = 8'h96;
    repeat (16) @(negedge ref_clk);
    chk({busy, done, err, wr_take, rd_valid, scl_out, sda_oe, write_protect_in, rd_data}, 16'h0400);
    chk(sda_out, 1'h0);
    resetn = 1;
    repeat (4) @(negedge ref_clk);
    // Page write across the row end, top bit set, with polling
    run(OP_WRITE, 16'hBF3F, 7'h03, 1'h0);
    chk(i_mem.mem[8'h3F], wq[0]);
    run(OP_RAND_READ, 16'h3F00, 7'h02, 1'h0);
    chk(16'(rq.size()), 16'h0002);
    chk(rq[0], wq[1]);
    chk(rq[1], wq[2]);
    // Protected write: data byte refused
    protect_req = 1;
    run(OP_WRITE, 16'h0010, 7'h01, 1'h1);
    chk(i_mem.mem[8'h10], 8'hFF);
    protect_req = 0;
    // Foreign type code: select refused
    code = 4'h3;
    run(OP_CUR_READ, 16'h0000, 7'h01, 1'h1);
    chk(16'(rq.size()), 16'h0000);
    code = 4'h9;
    dev_power_ok = 0;
    repeat (4) @(negedge ref_clk);
    cmd_valid = 1;
    repeat (8) @(negedge ref_clk);
    chk(busy, 1'h0);
    cmd_valid = 0;
    results();
  end
endmodule
